// >>> station_id_defs.svh
`ifndef STATION_ID_DEFS_SVH
`define STATION_ID_DEFS_SVH

// Register offsets in the controller memory map.
`define STATION_ALIAS_OFFSET 16'h0012
`define APP_LAYER_STATUS_OFFSET 16'h0134

// Default place of the identification word in process data.
`define IDENTITY_WORD_DEFAULT_OFFSET 16'h1000

// Word address of the second station address inside the configuration EEPROM.
`define ALIAS_EEPROM_WORD_DEFAULT 16'h0004

// Reset values.
`define ALIAS_RESET_VALUE 16'h0000
`define READ_DATA_RESET_VALUE 16'h0000

// EEPROM answer timeout, in microseconds, and the clock rate in MHz.
`define EEPROM_TIMEOUT_US 100
`define SYS_CLK_MHZ 250

`endif

// >>> station_id_pkg.sv
package station_id_pkg;

	// Read request from the frame processor into controller memory.
	typedef struct packed {
		logic rd;
		logic [15:0] addr;
	} mem_req_t;

	// Read answer back to the frame processor.
	typedef struct packed {
		logic valid;
		logic hit;
		logic [15:0] data;
	} mem_rsp_t;

	// Start-up load sequence of the alias register.
	typedef enum logic [3:0] {
		LOAD_START = 4'h1,
		LOAD_WAIT = 4'h2,
		LOAD_DONE = 4'h4,
		LOAD_FAIL = 4'h8
	} load_state_t;

endpackage : station_id_pkg

// >>> station_id.sv
`timescale 1ns/100ps
`default_nettype none
`include "station_id_defs.svh"

module station_id
	import station_id_pkg::*;
#(
	parameter logic [15:0] IDENTITY_OFFSET = `IDENTITY_WORD_DEFAULT_OFFSET,
	parameter logic [15:0] ALIAS_EEPROM_WORD = `ALIAS_EEPROM_WORD_DEFAULT,
	parameter int ID_WIDTH = 16,
	parameter int EEPROM_TIMEOUT_CYCLES = `EEPROM_TIMEOUT_US * `SYS_CLK_MHZ
)
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire mem_req_t mem_req_i,
	output mem_rsp_t mem_rsp_o,
	output logic eeprom_req_o,
	output logic [15:0] eeprom_addr_o,
	input wire logic eeprom_ack_i,
	input wire logic eeprom_err_i,
	input wire logic [15:0] eeprom_data_i,
	input wire logic [ID_WIDTH-1:0] id_switch_i,
	input wire logic id_word_enable_i,
	input wire logic explicit_id_req_i,
	input wire logic [15:0] al_status_i,
	output logic alias_valid_o,
	output logic alias_load_error_o
);

	localparam int TIMER_WIDTH = $clog2(EEPROM_TIMEOUT_CYCLES + 1);

	// Bad settings are refused while the design is elaborated, before any cycle runs.
	if (ID_WIDTH != 16)
	begin : g_check_width
		$error("station_id: the identity is exactly 16 bits wide");
	end
	if (EEPROM_TIMEOUT_CYCLES < 1)
	begin : g_check_timeout
		$error("station_id: the EEPROM timeout must be at least one cycle");
	end
	if (IDENTITY_OFFSET == `STATION_ALIAS_OFFSET || IDENTITY_OFFSET == `APP_LAYER_STATUS_OFFSET)
	begin : g_check_offset
		$error("station_id: identity offset collides with a register");
	end

	// Start-up load of the alias register.
	load_state_t load_state_reg;
	load_state_t load_state_next;
	logic [15:0] station_alias_reg;
	logic [15:0] station_alias_next;
	logic eeprom_req_reg;
	logic eeprom_req_next;
	logic [15:0] eeprom_addr_reg;
	logic [15:0] eeprom_addr_next;
	logic alias_valid_reg;
	logic alias_valid_next;
	logic load_error_reg;
	logic load_error_next;
	logic [TIMER_WIDTH-1:0] timer_reg;
	logic [TIMER_WIDTH-1:0] timer_next;

	always_comb
	begin
		load_state_next = load_state_reg;
		station_alias_next = station_alias_reg;
		eeprom_req_next = eeprom_req_reg;
		eeprom_addr_next = eeprom_addr_reg;
		alias_valid_next = alias_valid_reg;
		load_error_next = load_error_reg;
		timer_next = timer_reg;
		unique case (load_state_reg)
			LOAD_START:
			begin
				eeprom_req_next = 1'b1;
				eeprom_addr_next = ALIAS_EEPROM_WORD;
				timer_next = TIMER_WIDTH'(EEPROM_TIMEOUT_CYCLES);
				load_state_next = LOAD_WAIT;
			end
			LOAD_WAIT:
			begin
				if (eeprom_ack_i)
				begin
					eeprom_req_next = 1'b0;
					if (eeprom_err_i)
					begin
						load_error_next = 1'b1;
						load_state_next = LOAD_FAIL;
					end
					else
					begin
						station_alias_next = eeprom_data_i;
						alias_valid_next = 1'b1;
						load_state_next = LOAD_DONE;
					end
				end
				else if (timer_reg == '0)
				begin
					// A silent EEPROM must not hang start-up; the alias then reads as its reset value.
					eeprom_req_next = 1'b0;
					load_error_next = 1'b1;
					load_state_next = LOAD_FAIL;
				end
				else
				begin
					timer_next = timer_reg - 1'b1;
				end
			end
			LOAD_DONE:
			begin
				// Later EEPROM writes are not followed; only a reset through rstn_i reloads.
				load_state_next = LOAD_DONE;
			end
			LOAD_FAIL:
			begin
				load_state_next = LOAD_FAIL;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			load_state_reg <= LOAD_START;
			station_alias_reg <= `ALIAS_RESET_VALUE;
			eeprom_req_reg <= 1'b0;
			eeprom_addr_reg <= ALIAS_EEPROM_WORD;
			alias_valid_reg <= 1'b0;
			load_error_reg <= 1'b0;
			timer_reg <= '0;
		end
		else
		begin
			load_state_reg <= load_state_next;
			station_alias_reg <= station_alias_next;
			eeprom_req_reg <= eeprom_req_next;
			eeprom_addr_reg <= eeprom_addr_next;
			alias_valid_reg <= alias_valid_next;
			load_error_reg <= load_error_next;
			timer_reg <= timer_next;
		end
	end

	// The identity switch is an asynchronous pin; each bit passes two flip-flops.
	logic [ID_WIDTH-1:0] id_meta_reg;
	logic [ID_WIDTH-1:0] id_sync_reg;
	logic [ID_WIDTH-1:0] id_meta_next;
	logic [ID_WIDTH-1:0] id_sync_next;

	genvar bit_idx;
	generate
		for (bit_idx = 0; bit_idx < ID_WIDTH; bit_idx++)
		begin : g_id_sync
			always_comb
			begin
				id_meta_next[bit_idx] = id_switch_i[bit_idx];
				id_sync_next[bit_idx] = id_meta_reg[bit_idx];
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			id_meta_reg <= '0;
			id_sync_reg <= '0;
		end
		else
		begin
			id_meta_reg <= id_meta_next;
			id_sync_reg <= id_sync_next;
		end
	end

	// Read port toward the frame processor; answer one cycle after the request.
	mem_rsp_t rsp_reg;
	mem_rsp_t rsp_next;

	always_comb
	begin
		rsp_next.valid = mem_req_i.rd;
		rsp_next.hit = 1'b0;
		rsp_next.data = `READ_DATA_RESET_VALUE;
		if (mem_req_i.rd)
		begin
			if (mem_req_i.addr == `STATION_ALIAS_OFFSET)
			begin
				rsp_next.hit = 1'b1;
				rsp_next.data = station_alias_reg;
			end
			else if (mem_req_i.addr == `APP_LAYER_STATUS_OFFSET)
			begin
				rsp_next.hit = 1'b1;
				// The status word is lent to the identity only while the master asks for it.
				rsp_next.data = explicit_id_req_i ? id_sync_reg : al_status_i;
			end
			else if (id_word_enable_i && mem_req_i.addr == IDENTITY_OFFSET)
			begin
				rsp_next.hit = 1'b1;
				rsp_next.data = id_sync_reg;
			end
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			rsp_reg <= '0;
		end
		else
		begin
			rsp_reg <= rsp_next;
		end
	end

	assign mem_rsp_o = rsp_reg;
	assign eeprom_req_o = eeprom_req_reg;
	assign eeprom_addr_o = eeprom_addr_reg;
	assign alias_valid_o = alias_valid_reg;
	assign alias_load_error_o = load_error_reg;

endmodule : station_id

`default_nettype wire

// >>> station_id_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module station_id_monitor
	import station_id_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire mem_req_t mem_req_i,
	input wire mem_rsp_t mem_rsp_o,
	input wire logic eeprom_req_o,
	input wire logic [15:0] eeprom_addr_o,
	input wire logic eeprom_ack_i,
	input wire logic eeprom_err_i,
	input wire logic [15:0] eeprom_data_i,
	input wire logic [15:0] id_switch_i,
	input wire logic id_word_enable_i,
	input wire logic explicit_id_req_i,
	input wire logic [15:0] al_status_i,
	input wire logic alias_valid_o,
	input wire logic alias_load_error_o
);
	// Only a good answer to a pending request may load, so late words are ignored.
	logic [15:0] alias_reg;
	logic [15:0] alias_next;
	always_comb alias_next = (eeprom_req_o && eeprom_ack_i && !eeprom_err_i) ? eeprom_data_i : alias_reg;
	always_ff @(posedge sys_clk_i) alias_reg <= rstn_i ? alias_next : 16'h0000;
	default clocking dc @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);
	sequence s_rd(a);
		mem_req_i.rd && mem_req_i.addr == a;
	endsequence
	property p_alias;
		s_rd(16'h0012) |=> mem_rsp_o.hit && mem_rsp_o.data == $past(alias_reg);
	endproperty
	property p_start;
		$rose(rstn_i) |=> eeprom_req_o && eeprom_addr_o == 16'h0004;
	endproperty
	property p_load;
		eeprom_req_o && eeprom_ack_i |=> !eeprom_req_o && alias_load_error_o == $past(eeprom_err_i);
	endproperty
	property p_keep;
		alias_valid_o |=> alias_valid_o && !eeprom_req_o;
	endproperty
	property p_word;
		s_rd(16'h1000) |=> mem_rsp_o.data == ($past(id_word_enable_i) ? $past(id_switch_i, 3) : 16'h0000);
	endproperty
	property p_expl;
		s_rd(16'h0134) |=> mem_rsp_o.data == ($past(explicit_id_req_i) ? $past(id_switch_i, 3) : $past(al_status_i));
	endproperty
	property p_valid;
		mem_rsp_o.valid == $past(mem_req_i.rd);
	endproperty
	a_alias: assert property (p_alias) else $error("alias read wrong");
	a_start: assert property (p_start) else $error("no load at start");
	a_load: assert property (p_load) else $error("load end wrong");
	a_keep: assert property (p_keep) else $error("alias reloaded");
	a_word: assert property (p_word) else $error("id word wrong");
	a_expl: assert property (p_expl) else $error("status id wrong");
	a_valid: assert property (p_valid) else $error("valid timing");
endmodule : station_id_monitor
bind station_id station_id_monitor u_station_id_monitor (.sys_clk_i, .rstn_i, .mem_req_i, .mem_rsp_o, .eeprom_req_o,
	.eeprom_addr_o, .eeprom_ack_i, .eeprom_err_i, .eeprom_data_i, .id_switch_i, .id_word_enable_i, .explicit_id_req_i,
	.al_status_i, .alias_valid_o, .alias_load_error_o);
`default_nettype wire

// >>> eeprom_model.sv
`timescale 1ns/100ps
`default_nettype none
module eeprom_model
(
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic [15:0] word_i,
	input wire logic [1:0] mode_i,
	output logic ack_o,
	output logic err_o,
	output logic [15:0] data_o
);
	logic [3:0] n = 4'h0;
	initial data_o = 16'h0000;
	initial ack_o = 1'b0;
	initial err_o = 1'b0;
	// Data toggles outside the answer so a stale word is never mistaken for a good one.
	always @(posedge clk_i)
	begin
		ack_o <= 1'b0;
		data_o <= ~data_o;
		n <= (req_i && !ack_o) ? n + 4'h1 : 4'h0;
		if (req_i && !ack_o && n == 4'h6 && mode_i != 2'h2)
		begin
			ack_o <= 1'b1;
			err_o <= mode_i == 2'h1;
			data_o <= word_i;
		end
	end
endmodule : eeprom_model
`default_nettype wire

// >>> station_id_tb.sv
`timescale 1ns/100ps
`default_nettype none
module station_id_tb;
	import station_id_pkg::*;
	logic sys_clk_i = 0, rstn_i = 0, eeprom_req_o, eeprom_ack_i, eeprom_err_i, alias_valid_o, alias_load_error_o;
	logic id_word_enable_i = 0, explicit_id_req_i = 0;
	logic [15:0] eeprom_addr_o, eeprom_data_i, id_switch_i = 16'hbeef, al_status_i = 16'h0002, word = 16'h1234;
	logic [1:0] mode = 2'h0;
	mem_req_t mem_req_i = '0;
	mem_rsp_t mem_rsp_o;
	int fail_count = 0, n_compared = 0, cyc = 0;
	station_id #(.EEPROM_TIMEOUT_CYCLES(20)) u_station_id (.sys_clk_i, .rstn_i, .mem_req_i, .mem_rsp_o, .eeprom_req_o,
		.eeprom_addr_o, .eeprom_ack_i, .eeprom_err_i, .eeprom_data_i, .id_switch_i, .id_word_enable_i,
		.explicit_id_req_i, .al_status_i, .alias_valid_o, .alias_load_error_o);
	eeprom_model u_eeprom_model (.clk_i(sys_clk_i), .req_i(eeprom_req_o), .word_i(word), .mode_i(mode),
		.ack_o(eeprom_ack_i), .err_o(eeprom_err_i), .data_o(eeprom_data_i));
	initial forever #2 sys_clk_i = ~sys_clk_i;
	task complete_run;
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	always @(posedge sys_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			fail_count++;
			complete_run();
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task rd(input logic [15:0] a, input logic [15:0] d, input logic h);
		@(posedge sys_clk_i);
		mem_req_i <= '{rd: 1'b1, addr: a};
		@(posedge sys_clk_i);
		mem_req_i <= '0;
		#1;
		chk({14'h0, mem_rsp_o.valid, mem_rsp_o.hit}, {14'h0, 1'b1, h});
		chk(mem_rsp_o.data, d);
		@(posedge sys_clk_i);
	endtask : rd
	task boot(input logic [1:0] m);
		@(posedge sys_clk_i);
		mode <= m;
		rstn_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		rd(16'h0012, 16'h0000, 1'b1);
		for (int i = 0; i < 40 && !(alias_valid_o || alias_load_error_o); i++)
		begin
			@(posedge sys_clk_i);
			#1;
		end
		chk({15'h0, alias_valid_o}, {15'h0, m == 2'h0});
		chk({15'h0, alias_load_error_o}, {15'h0, m != 2'h0});
	endtask : boot
	initial
	begin
		boot(2'h0);
		rd(16'h0012, 16'h1234, 1'b1);
		word <= 16'h5678;
		rd(16'h0012, 16'h1234, 1'b1);
		rd(16'h0014, 16'h0000, 1'b0);
		rd(16'h1000, 16'h0000, 1'b0);
		id_word_enable_i <= 1'b1;
		rd(16'h1000, 16'hbeef, 1'b1);
		rd(16'h0134, 16'h0002, 1'b1);
		explicit_id_req_i <= 1'b1;
		id_switch_i <= 16'hffff;
		repeat (3) @(posedge sys_clk_i);
		rd(16'h0134, 16'hffff, 1'b1);
		boot(2'h1);
		rd(16'h0012, 16'h0000, 1'b1);
		boot(2'h2);
		boot(2'h0);
		rd(16'h0012, 16'h5678, 1'b1);
		complete_run();
	end
endmodule : station_id_tb
`default_nettype wire
